// *** prm_mode_ctrl.sv ***
// Functional notes
// (RL1) Mapping on: every address, vectors too, goes through the chosen set.
// (RL2) Each page relocates alone; pages may share physical space.
// (RL3) Page base may lie above or below its virtual range.
// (RL4) Page bases fall on 64-byte boundaries.
// (RL5) Per-page key: read/write, read-only or nonresident, checked each access.
// (RL6) Three modes; kernel may execute every instruction.
// (RL7) User and supervisor refuse halt and bus reset.
// (RL8) Supervisor acts like user but maps through its own set.
// (RL9) Mapping registers live in the peripheral page only; only writes check reg_io_page_i, reads decode in any page.
// (RL10) Vectors are kernel data-space addresses; two words fetched via kernel map.
// (RL11) Old counter and status pushed onto the stack of the new mode.
// (RL12) New status mode bits 15:14 choose the set after the vector.
// (RL13) Software sets the split enable bit in config register three.
// (RL14) Split on: eight instruction and eight data pages per mode.
// (RL15) Instruction space gets fetches, immediates, absolutes, index words only.
// (RL16) Top three virtual bits pick one of eight page pairs.
// (RL17) Status mode field selects the register set.
// (RL18) Config three bits 2:0 enable data space per mode.
// (RL19) Without data space, every reference uses the instruction set.
// (RL20) Physical address is base times 64 plus page offset.
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module prm_mode_ctrl
  import prm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic reg_io_page_i,
  output logic [15:0] reg_rdata_o,
  input wire logic [15:0] processor_status_word_i,
  input wire prm_pkg::prm_req_t req_i,
  output prm_pkg::prm_rsp_t rsp_o,
  input wire logic vector_i,
  input wire logic [VA_W-1:0] vector_addr_i,
  input wire logic priv_instr_i,
  output logic priv_refuse_o,
  output logic vec_busy_o,
  output logic [1:0] push_mode_o,
  output logic push_o
);
  import prm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] cfg3;
    logic [15:0] fault;
    prm_state_t st;
    logic [15:0] new_psw;
    logic [1:0] cur_mode;
    logic [1:0] push_mode;
    logic push;
    logic refuse;
    prm_rsp_t rsp;
    logic rd_pend;
    logic [7:0] rd_addr;
  } prm_st_t;

  prm_st_t s_q, s_d;
  logic map_on;
  logic [1:0] eff_mode;
  logic use_d;
  logic [1:0] d_sel;
  logic i_ref;
  logic [5:0] tbl_idx;
  logic [5:0] w_idx;
  logic base_we;
  logic key_we;
  logic [BASE_W-1:0] base_rd;
  logic [BASE_W-1:0] key_rd;
  logic [VA_W-1:0] eff_va;
  logic eff_valid;
  logic eff_write;
  logic [OFS_W-1:0] ofs_q;
  logic [PAGE_SEL_W-1:0] page_q;
  logic lkp_q;
  logic lkp_write_q;
  logic lkp_d_q;
  logic [1:0] lkp_mode_q;
  logic [VA_W-1:0] va_q;

  ////////////////////////////////////////////////////////////////////////////
  // Lookup of base and key tables
  assign map_on = s_q.ctrl[0];
  assign eff_valid = req_i.valid || (s_q.st inside {ST_VEC_PC, ST_VEC_PSW});
  assign eff_write = (s_q.st == ST_IDLE) && req_i.write;
  always_comb begin
    eff_va = req_i.vaddr;
    eff_mode = processor_status_word_i[MODE_HI:MODE_LO]; // RL17
    if (s_q.st == ST_VEC_PC) begin
      eff_va = vector_addr_i; // RL10
      eff_mode = MODE_KERNEL; // RL10
    end else if (s_q.st == ST_VEC_PSW) begin
      eff_va = vector_addr_i + 16'h0002; // RL10
      eff_mode = MODE_KERNEL;
    end else if (s_q.st == ST_PUSH) begin
      eff_mode = s_q.new_psw[MODE_HI:MODE_LO]; // RL12
    end
  end
  always_comb begin
    i_ref = 1'b0;
    if (s_q.st == ST_IDLE) begin
      // RL15
      case (req_i.kind)
        REF_INSTR: i_ref = 1'b1;
        REF_INDEX: i_ref = 1'b1;
        REF_IMMABS: i_ref = (req_i.areg == REG_PC) &&
          (req_i.amode inside {AMODE_AUTOINC, AMODE_AUTOINC_DEF});
        default: i_ref = 1'b0;
      endcase
    end
  end
  // RL13 RL18 RL19
  // User mode enable sits in bit 2, not in the split bit
  assign d_sel = (eff_mode == MODE_USER) ? 2'h2 : eff_mode;
  assign use_d = s_q.cfg3[CFG3_SPLIT_BIT] && s_q.cfg3[d_sel] && !i_ref;
  // RL14 RL16
  assign tbl_idx = {eff_mode, use_d, eff_va[VA_W-1 -: PAGE_SEL_W]};
  assign w_idx = reg_addr_i[5:0];
  // RL9
  assign base_we = reg_we_i && reg_io_page_i && reg_addr_i[7:6] == 2'h1;
  assign key_we = reg_we_i && reg_io_page_i && reg_addr_i[7:6] == 2'h2;

  prm_map_ram #(.DW(BASE_W), .AW(6)) u_base (
    .clk_i(clk_i),
    .we_i(base_we),
    .waddr_i(w_idx),
    .wdata_i(reg_wdata_i),
    .raddr_i(reg_re_i ? w_idx : tbl_idx),
    .rdata_o(base_rd)
  );
  prm_map_ram #(.DW(BASE_W), .AW(6)) u_key (
    .clk_i(clk_i),
    .we_i(key_we),
    .waddr_i(w_idx),
    .wdata_i(reg_wdata_i),
    .raddr_i(reg_re_i ? w_idx : tbl_idx),
    .rdata_o(key_rd)
  );

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lkp_q <= 1'b0;
      lkp_write_q <= 1'b0;
      lkp_d_q <= 1'b0;
      lkp_mode_q <= 2'h0;
      va_q <= 16'h0000;
    end else begin
      lkp_q <= eff_valid && !reg_re_i;
      lkp_write_q <= eff_write;
      lkp_d_q <= use_d;
      lkp_mode_q <= eff_mode;
      va_q <= eff_va;
    end
  end
  assign ofs_q = va_q[OFS_W-1:0];
  assign page_q = va_q[VA_W-1 -: PAGE_SEL_W];

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.push = 1'b0;
    s_d.refuse = 1'b0;
    s_d.rsp.valid = 1'b0;
    s_d.rd_pend = reg_re_i;
    s_d.rd_addr = reg_addr_i;
    s_d.cur_mode = processor_status_word_i[MODE_HI:MODE_LO];
    // RL6 RL7 RL8
    if (priv_instr_i && s_d.cur_mode != MODE_KERNEL) begin
      s_d.refuse = 1'b1;
    end
    if (reg_we_i && reg_io_page_i) begin // RL9
      if (reg_addr_i == OFS_CTRL) begin
        s_d.ctrl = reg_wdata_i;
      end
      if (reg_addr_i == OFS_CFG3) begin
        s_d.cfg3 = reg_wdata_i;
      end
    end
    if (lkp_q) begin
      s_d.rsp.valid = 1'b1;
      s_d.rsp.dspace = lkp_d_q;
      s_d.rsp.mode = lkp_mode_q;
      s_d.rsp.trap = 1'b0;
      s_d.rsp.abort = 1'b0;
      if (map_on) begin
        // RL1 RL2 RL3 RL4 RL20
        s_d.rsp.paddr = PA_W'({base_rd, {BLK_SHIFT{1'b0}}}) + PA_W'(ofs_q);
        // RL5
        case (key_rd[KEY_W-1:0])
          KEY_RO_TRAP: begin
            s_d.rsp.abort = lkp_write_q;
            s_d.rsp.trap = !lkp_write_q;
          end
          KEY_RO: s_d.rsp.abort = lkp_write_q;
          KEY_RW_TRAP: s_d.rsp.trap = 1'b1;
          KEY_RW: s_d.rsp.abort = 1'b0;
          default: s_d.rsp.abort = 1'b1;
        endcase
        if (s_d.rsp.abort) begin
          s_d.fault = {8'h00, 1'b0, lkp_mode_q, lkp_d_q, 1'b0, page_q};
        end
      end else begin
        s_d.rsp.paddr = PA_W'(va_q);
      end
    end
    case (s_q.st)
      ST_IDLE: begin
        if (vector_i) begin
          s_d.st = ST_VEC_PC;
        end
      end
      ST_VEC_PC: s_d.st = ST_VEC_PSW;
      ST_VEC_PSW: begin
        s_d.new_psw = processor_status_word_i;
        s_d.st = ST_PUSH;
      end
      ST_PUSH: begin
        s_d.push = 1'b1; // RL11
        s_d.push_mode = s_q.new_psw[MODE_HI:MODE_LO]; // RL11
        s_d.st = ST_IDLE;
      end
      default: s_d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q <= '0;
      s_q.ctrl <= CTRL_RST;
      s_q.cfg3 <= CFG3_RST;
      s_q.st <= ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_comb begin
    reg_rdata_o = 16'h0000;
    if (s_q.rd_pend) begin
      case (s_q.rd_addr[7:6])
        2'h1: reg_rdata_o = base_rd;
        2'h2: reg_rdata_o = {13'h0000, key_rd[KEY_W-1:0]};
        default: begin
          case (s_q.rd_addr)
            OFS_CTRL: reg_rdata_o = s_q.ctrl;
            OFS_CFG3: reg_rdata_o = s_q.cfg3;
            OFS_STAT: reg_rdata_o = {12'h000, s_q.cur_mode, 1'b0, map_on};
            OFS_FAULT: reg_rdata_o = s_q.fault;
            default: reg_rdata_o = 16'h0000;
          endcase
        end
      endcase
    end
  end
  assign rsp_o = s_q.rsp;
  assign priv_refuse_o = s_q.refuse;
  assign push_o = s_q.push;
  assign push_mode_o = s_q.push_mode;
  assign vec_busy_o = s_q.st != ST_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_priv_refuse: assert property (@(posedge clk_i) disable iff (!rstn_i)
    priv_instr_i && processor_status_word_i[15:14] != 2'h0 |=> priv_refuse_o)
    else $error("privileged op not refused"); // RL7
  chk_kernel_free: assert property (@(posedge clk_i) disable iff (!rstn_i)
    priv_instr_i && processor_status_word_i[15:14] == 2'h0 |=> !priv_refuse_o)
    else $error("kernel op refused"); // RL6
  chk_vec_seq: assert property (@(posedge clk_i) disable iff (!rstn_i)
    vector_i && !vec_busy_o |=> vec_busy_o [*3] ##1 !vec_busy_o)
    else $error("vector sequence length wrong"); // RL10
  chk_push_mode: assert property (@(posedge clk_i) disable iff (!rstn_i)
    push_o |-> push_mode_o == $past(s_q.new_psw[15:14]))
    else $error("push stack mode wrong"); // RL11
  chk_vec_kernel: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_q.st == ST_VEC_PC |=> lkp_mode_q == 2'h0)
    else $error("vector not via kernel map"); // RL10
  chk_rsp_lat: assert property (@(posedge clk_i) disable iff (!rstn_i)
    req_i.valid && !reg_re_i |-> ##2 rsp_o.valid)
    else $error("response missing"); // RL1
  chk_nonres: assert property (@(posedge clk_i) disable iff (!rstn_i)
    lkp_q && map_on && key_rd[2:0] == 3'h0 |=> rsp_o.abort)
    else $error("nonresident not aborted"); // RL5
  chk_ro_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
    lkp_q && map_on && lkp_write_q && key_rd[2:0] == 3'h2 |=> rsp_o.abort)
    else $error("read-only write not aborted"); // RL5
  chk_blk_align: assert property (@(posedge clk_i) disable iff (!rstn_i)
    lkp_q && map_on |=> rsp_o.paddr[5:0] == $past(va_q[5:0]))
    else $error("page base not block aligned"); // RL4
  chk_split_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !s_q.cfg3[3] |-> !use_d)
    else $error("data space used without split"); // RL19
  cov_vector: cover property (@(posedge clk_i) push_o);
  cov_dspace: cover property (@(posedge clk_i) rsp_o.valid && rsp_o.dspace);
  cov_abort: cover property (@(posedge clk_i) rsp_o.valid && rsp_o.abort);
  cov_trap: cover property (@(posedge clk_i) rsp_o.valid && rsp_o.trap);
endmodule : prm_mode_ctrl
`default_nettype wire

// *** prm_pkg.sv ***
package prm_pkg;

  localparam int VA_W = 16;
  localparam int PA_W = 22;
  localparam int PAGE_SEL_W = 3;
  localparam int NUM_PAGES = 8;
  localparam int BLK_SHIFT = 6;
  localparam int OFS_W = VA_W - PAGE_SEL_W;
  localparam int BASE_W = 16;
  localparam int KEY_W = 3;
  localparam int NUM_MODES = 4;
  localparam int MODE_HI = 15;
  localparam int MODE_LO = 14;

  localparam logic [1:0] MODE_KERNEL = 2'h0;
  localparam logic [1:0] MODE_SUPER = 2'h1;
  localparam logic [1:0] MODE_USER = 2'h3;

  localparam logic [2:0] KEY_NONRES = 3'h0;
  localparam logic [2:0] KEY_RO_TRAP = 3'h1;
  localparam logic [2:0] KEY_RO = 3'h2;
  localparam logic [2:0] KEY_RW_TRAP = 3'h4;
  localparam logic [2:0] KEY_RW = 3'h5;

  localparam logic [2:0] AMODE_AUTOINC = 3'h2;
  localparam logic [2:0] AMODE_AUTOINC_DEF = 3'h3;
  localparam logic [2:0] REG_PC = 3'h7;

  // Register port offsets (word index)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG3 = 8'h01;
  localparam logic [7:0] OFS_STAT = 8'h02;
  localparam logic [7:0] OFS_FAULT = 8'h03;
  localparam logic [7:0] OFS_BASE0 = 8'h40;
  localparam logic [7:0] OFS_KEY0 = 8'h80;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] CFG3_RST = 16'h0000;
  localparam int CFG3_SPLIT_BIT = 3;

  typedef enum logic [1:0] {
    REF_INSTR = 2'b00,
    REF_IMMABS = 2'b01,
    REF_INDEX = 2'b10,
    REF_DATA = 2'b11
  } prm_ref_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_VEC_PC = 2'b01,
    ST_VEC_PSW = 2'b10,
    ST_PUSH = 2'b11
  } prm_state_t;

  typedef struct packed {
    logic valid;
    logic [VA_W-1:0] vaddr;
    logic write;
    prm_ref_t kind;
    logic [2:0] amode;
    logic [2:0] areg;
  } prm_req_t;

  typedef struct packed {
    logic valid;
    logic [PA_W-1:0] paddr;
    logic abort;
    logic trap;
    logic dspace;
    logic [1:0] mode;
  } prm_rsp_t;

endpackage : prm_pkg

// *** prm_map_ram.sv ***
`timescale 1ns/1ps
`default_nettype none
module prm_map_ram #(
  parameter int DW = 16,
  parameter int AW = 6
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem_q [2**AW];
  if (DW < 1 || AW < 1) begin : g_bad_size
    $error("prm_map_ram bad size");
  end
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_q[raddr_i];
  end
endmodule : prm_map_ram
`default_nettype wire

// *** prm_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module prm_core_model (
  input wire logic clk_i,
  output prm_pkg::prm_req_t req_o,
  output logic [15:0] psw_o
);
  import prm_pkg::*;
  initial begin
    req_o = '0;
    psw_o = 16'h0000;
  end
  // One reference held for one edge, then the lines are scrambled
  task automatic issue(input logic [15:0] va, input prm_ref_t k,
    input logic [2:0] am, input logic [2:0] ar, input logic w);
    @(posedge clk_i);
    req_o <= '{1'b1, va, w, k, am, ar};
    @(posedge clk_i);
    req_o <= '{1'b0, ~va, ~w, k, ~am, ~ar};
  endtask : issue
  // Mode field sits in bits 15:14
  task automatic set_mode(input logic [1:0] m);
    @(posedge clk_i);
    psw_o <= {m, 14'h0000};
  endtask : set_mode
endmodule : prm_core_model
`default_nettype wire

// *** tb_prm_mode_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_prm_mode_ctrl;
  import prm_pkg::*;
  logic clk_i, rstn_i, we, re, pg, vec, priv;
  logic refuse, busy, push, re_s, priv_s;
  logic [7:0] addr;
  logic [15:0] wd, rdata, processor_status_word, va_v, ctrl, cfg;
  logic [1:0] pmode, cur;
  logic [15:0] base [64];
  logic [2:0] key [64];
  prm_req_t req;
  prm_rsp_t rsp;
  prm_rsp_t rq [$];
  logic [15:0] dq [$];
  int num_errors, checks, seed, pushes;
  prm_mode_ctrl u_prm_mode_ctrl (.clk_i(clk_i), .rstn_i(rstn_i),
    .reg_addr_i(addr), .reg_wdata_i(wd), .reg_we_i(we), .reg_re_i(re),
    .reg_io_page_i(pg), .reg_rdata_o(rdata),
    .processor_status_word_i(processor_status_word), .req_i(req), .rsp_o(rsp),
    .vector_i(vec), .vector_addr_i(va_v), .priv_instr_i(priv),
    .priv_refuse_o(refuse), .vec_busy_o(busy), .push_mode_o(pmode),
    .push_o(push));
  prm_core_model u_prm_core_model (.clk_i(clk_i), .req_o(req),
    .psw_o(processor_status_word));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic cmp_rsp(input prm_rsp_t e, input prm_rsp_t g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH rsp expected %h seen %h", e, g);
    end
  endtask : cmp_rsp
  task automatic cmp_val(input string n, input logic [15:0] e, g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : cmp_val
  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  function automatic prm_rsp_t exp_rsp(input logic [15:0] va,
    input prm_ref_t k, input logic [2:0] am, ar, input logic w,
    input logic [1:0] m);
    prm_rsp_t r;
    logic [5:0] i;
    logic [2:0] ky;
    r = '0;
    r.valid = 1'b1;
    r.mode = m;
    r.dspace = cfg[CFG3_SPLIT_BIT] && cfg[(m == MODE_USER) ? 2 : m] &&
      !(k == REF_INSTR || k == REF_INDEX || (k == REF_IMMABS &&
      ar == REG_PC && am inside {AMODE_AUTOINC, AMODE_AUTOINC_DEF}));
    i = {m, r.dspace, va[15:13]};
    ky = key[i];
    if (ctrl[0]) begin
      r.paddr = PA_W'({base[i], 6'h00}) + PA_W'(va[12:0]);
      r.abort = ky inside {KEY_NONRES, 3'h3, 3'h6, 3'h7} ||
        (w && ky inside {KEY_RO_TRAP, KEY_RO});
      r.trap = (!w && ky == KEY_RO_TRAP) || ky == KEY_RW_TRAP;
    end else begin
      r.paddr = PA_W'(va);
    end
    return r;
  endfunction : exp_rsp
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
    input logic p = 1'b1);
    @(posedge clk_i);
    addr <= a;
    wd <= d;
    we <= 1'b1;
    pg <= p;
    if (p && a >= OFS_KEY0) key[a[5:0]] = d[2:0];
    else if (p && a >= OFS_BASE0) base[a[5:0]] = d;
    else if (p && a == OFS_CTRL) ctrl = d;
    else if (p && a == OFS_CFG3) cfg = d;
    @(posedge clk_i);
    we <= 1'b0;
    pg <= 1'b1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_i);
    addr <= a;
    re <= 1'b1;
    dq.push_back(e);
    @(posedge clk_i);
    re <= 1'b0;
  endtask : rd
  task automatic ref_a(input logic [15:0] va, input prm_ref_t k,
    input logic [2:0] am = 3'h0, ar = 3'h0, input logic w = 1'b0);
    rq.push_back(exp_rsp(va, k, am, ar, w, cur));
    u_prm_core_model.issue(va, k, am, ar, w);
  endtask : ref_a
  task automatic set_m(input logic [1:0] m);
    cur = m;
    u_prm_core_model.set_mode(m);
  endtask : set_m
  task automatic pulse_priv(input logic e);
    @(posedge clk_i);
    priv <= 1'b1;
    dq.push_back({15'h0000, e});
    @(posedge clk_i);
    priv <= 1'b0;
  endtask : pulse_priv
  ////////////////////////////////////////////////////////////////////////
  // Results come off the queues in issue order
  always @(posedge clk_i) begin
    re_s <= re;
    priv_s <= priv;
    if (rsp.valid === 1'b1) begin
      cmp_rsp(rq.size() ? rq.pop_front() : '0, rsp);
    end
    if (re_s) begin
      cmp_val("rdata", dq.size() ? dq.pop_front() : 16'h0, rdata);
    end
    if (priv_s) cmp_val("refuse", dq.pop_front(), {15'h0000, refuse});
    if (push === 1'b1) begin
      pushes++;
      cmp_val("push", {14'h0000, MODE_USER}, {14'h0000, pmode});
    end
  end
  initial begin
    logic [1:0] ms [3];
    int n;
    ms = '{MODE_KERNEL, MODE_SUPER, MODE_USER};
    seed = 32'h1130;
    {rstn_i, we, re, pg, vec, priv, re_s, priv_s} = '0;
    {addr, wd, va_v, ctrl, cfg, cur} = '0;
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(OFS_CTRL, CTRL_RST);
    rd(OFS_CFG3, CFG3_RST);
    rd(8'h30, 16'h0000);
    ref_a(16'ha5a4, REF_DATA);
    for (int i = 0; i < 64; i++) begin
      wr(OFS_BASE0 + 8'(i), 16'($random(seed)));
      wr(OFS_KEY0 + 8'(i), {13'h0000, KEY_RW});
    end
    wr(OFS_BASE0 + 8'h06, base[4]);
    rd(OFS_BASE0 + 8'h06, base[4]);
    wr(OFS_CTRL, 16'h0001);
    for (int m = 0; m < 3; m++) begin
      set_m(ms[m]);
      for (int p = 0; p < 8; p++) begin
        ref_a({3'(p), 13'($random(seed))}, REF_DATA);
      end
    end
    set_m(MODE_KERNEL);
    ref_a(16'h8010, REF_DATA);
    ref_a(16'hc010, REF_DATA);
    for (int k = 0; k < 16; k++) begin
      wr(OFS_KEY0 + 8'h05, 16'(k >> 1));
      ref_a(16'ha123, REF_DATA, 3'h0, 3'h0, k[0]);
    end
    wr(OFS_KEY0 + 8'h05, {13'h0000, KEY_RW});
    rd(OFS_FAULT, 16'h0005);
    wr(OFS_CFG3, 16'h0009);
    rd(OFS_CFG3, 16'h0009);
    for (int j = 0; j < 32; j++) begin
      ref_a(16'(j * 1234), prm_ref_t'(j[1:0]), 3'(2 + j[4:3]),
        j[2] ? REG_PC : 3'h6);
    end
    for (int m = 0; m < 3; m++) begin
      set_m(ms[m]);
      ref_a(16'h6222, REF_DATA);
      pulse_priv(ms[m] != MODE_KERNEL);
    end
    set_m(MODE_USER);
    rq.push_back(exp_rsp(16'h0040, REF_DATA, 0, 0, 0, MODE_KERNEL));
    rq.push_back(exp_rsp(16'h0042, REF_DATA, 0, 0, 0, MODE_KERNEL));
    @(posedge clk_i);
    vec <= 1'b1;
    va_v <= 16'h0040;
    @(posedge clk_i);
    vec <= 1'b0;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (busy !== 1'b0 && n < 20);
    if (n >= 20) num_errors++;
    ref_a(16'h2468, REF_DATA);
    wr(OFS_CTRL, 16'h0000, 1'b0);
    rd(OFS_CTRL, 16'h0001);
    rd(OFS_STAT, 16'h000d);
    n = 0;
    while ((rq.size() || dq.size()) && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 50) num_errors++;
    cmp_val("pushes", 16'h0001, 16'(pushes));
    report_and_stop();
  end
endmodule : tb_prm_mode_ctrl
`default_nettype wire
